// ==== pkg/itc_defines.svh ====
/*
 * Offsets, field positions, reset values and event codes of the
 * isochronous transmit context control block.
 * Assumes a 12-bit APB byte address and 32-bit data words.
 */
// Overview of operation
// (RQ1) Armed context transmits in the target cycle
// (RQ2) Target compared with cycle start timer fields
// (RQ3) Armed context enabled when timer equals target
// (RQ4) Descriptor processing may start before send cycle
// (RQ5) Arm bit self-clears once context is active
// (RQ6) Software sets run to start, clears to stop
// (RQ7) Run changes only by software or reset
// (RQ8) Reserved bits 14:13 and 9:8 read zero
// (RQ9) Software sets wake; each fetch clears it
// (RQ10) Dead set on fatal error, cleared with run
// (RQ11) Active high while descriptors are processed
// (RQ12) Speed field meaningless, reads zero, ignored
// (RQ13) Last output descriptor writes completion code
// (RQ14) At most seven cycle skips per overflow
// (RQ15) Skips only when dead, timeout and fatal event
// (RQ16) Eight set/clear pairs at 200h and 204h
// (RQ17) Set/clear writes act on ones; reads return value
`ifndef ITC_DEFINES_SVH
`define ITC_DEFINES_SVH

// Context register window
`define ITC_CTX_COUNT      8
`define ITC_CTX_BASE       12'h200
`define ITC_CTX_STRIDE     12'h010
`define ITC_SET_OFS        4'h0
`define ITC_CLR_OFS        4'h4
// Interrupt registers, outside the context window
`define ITC_INT_STAT_ADDR  12'h300
`define ITC_INT_MASK_ADDR  12'h304

// Control word field positions
`define ITC_ARM_BIT        31
`define ITC_TGT_HI         30
`define ITC_TGT_LO         16
`define ITC_RUN_BIT        15
`define ITC_WAKE_BIT       12
`define ITC_DEAD_BIT       11
`define ITC_ACT_BIT        10
`define ITC_CODE_HI        4
`define ITC_CODE_LO        0

// Completion codes
`define ITC_CODE_COMPLETE  5'h11
`define ITC_CODE_DESC_RD   5'h04
`define ITC_CODE_DATA_RD   5'h05
`define ITC_CODE_TIMEOUT   5'h0a
`define ITC_CODE_UNKNOWN   5'h0e
`define ITC_CODE_RESET     5'h00

// Overflow skip ceiling
`define ITC_MAX_SKIPS      3'h7

// Interrupt status layout, one byte per event kind
`define ITC_INT_DEAD_LO    0
`define ITC_INT_DONE_LO    8
`define ITC_INT_OVF_LO     16

`endif

// ==== pkg/itc_pkg.sv ====
/*
 * Types of the isochronous transmit context control block.
 * Assumes the constants of itc_defines.svh.
 */
`default_nettype none
package itc_pkg;
    // Outcome reported by the transmit engine after a last descriptor
    typedef enum logic [2:0] {
        ITC_DONE_COMPLETE,
        ITC_DONE_DESC_READ,
        ITC_DONE_DATA_READ,
        ITC_DONE_TIMEOUT,
        ITC_DONE_OTHER
    } itc_done_e;
    // One completion code
    typedef logic [4:0]  itc_code_t;
    // One 15-bit cycle stamp: two seconds bits and cycle number
    typedef logic [14:0] itc_stamp_t;
endpackage
`default_nettype wire

// ==== pkg/itc_match_if.sv ====
/*
 * Interface between the control core and one cycle comparator.
 * Assumes one comparator per context, all on the same clock.
 */
`default_nettype none
interface itc_match_if;
    logic               armed;     // Compare armed and run set
    itc_pkg::itc_stamp_t target;   // Cycle to start in
    itc_pkg::itc_stamp_t stamp;    // Stamp of the latest cycle start
    logic               strobe;    // Cycle start seen this cycle
    logic               hit;       // Start cycle reached
    modport core (output armed, output target, output stamp, output strobe, input hit);
    modport cmp  (input armed, input target, input stamp, input strobe, output hit);
endinterface
`default_nettype wire

// ==== core/itc_cycle_match.sv ====
/*
 * Cycle comparator for one transmit context.
 * Assumes the stamp is the two low seconds bits and the 13-bit cycle
 * number captured from the cycle start packet of the strobe cycle.
 */
`default_nettype none
module itc_cycle_match (
    // Link to the control core
    itc_match_if.cmp m
);
    // Hit only on a cycle start whose stamp equals the target
    always_comb begin
        m.hit = m.armed & m.strobe & (m.stamp == m.target); // RQ2 RQ3
    end
endmodule
`default_nettype wire

// ==== core/itc_ctrl.sv ====
/*
 * Control and status for eight isochronous transmit DMA contexts:
 * APB register slave, cycle-compare start, wake, dead, active,
 * completion code, overflow skip budget and one interrupt output.
 * Assumes the descriptor engine, cycle timer and receive contexts sit
 * outside and talk over the plain ports below, synchronous to ref_clk.
 */
`include "itc_defines.svh"
`default_nettype none
module itc_ctrl (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        softReset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Cycle timer at each cycle start
    input  wire logic        cycleStart,
    input  wire logic [6:0]  timerSecondsCount,
    input  wire logic [12:0] timerCycleNumber,
    // Descriptor engine
    input  wire logic [7:0]  descFetch,
    input  wire logic [7:0]  engineBusy,
    input  wire logic [7:0]  fatalError,
    input  wire logic        doneValid,
    input  wire logic [2:0]  doneCtx,
    input  wire logic [2:0]  doneKind,
    input  wire logic [7:0]  overflow,
    output logic      [7:0]  ctxEnable,
    output logic      [7:0]  wakePending,
    output logic      [7:0]  skipGrant,
    // System error sources
    input  wire logic        rxDeadTimeout,
    input  wire logic        fatalErrorEvent,
    // Interrupt
    output logic             irq
);
    localparam int N = `ITC_CTX_COUNT;

    // Per-context control and status
    logic [7:0]                armReg;       // Cycle compare armed
    itc_pkg::itc_stamp_t       tgtReg [N];   // Target cycle
    logic [7:0]                runReg;       // Run bit
    logic [7:0]                wakeReg;      // Wake bit
    logic [7:0]                deadReg;      // Dead flag
    logic [7:0]                actReg;       // Active flag
    logic [7:0]                goReg;        // Context enabled to transmit
    itc_pkg::itc_code_t        codeReg [N];  // Completion code
    logic [2:0]                skipReg [N];  // Skips used since last packet
    logic [7:0]                skipOut_reg;  // Skip granted pulse
    logic [7:0]                ovfFail;      // Overflow refused: skip budget spent or skip handling not allowed
    wire logic [7:0]           hit;          // Comparator answers
    // Interrupt registers
    logic [23:0]               intStat_reg;
    logic [23:0]               intMask_reg;
    logic                      irq_reg;
    // APB registers
    logic [31:0]               rdata_reg;
    logic                      ready_reg;
    logic                      err_reg;
    logic                      clear;        // Hardware or software reset
    logic                      wrDone;       // Write completes this edge
    logic                      rdStart;      // Read data captured this edge
    logic [7:0]                setSel;       // Set address hit per context
    logic [7:0]                clrSel;       // Clear address hit per context
    logic                      skipOk;       // Skip handling applies
    itc_pkg::itc_stamp_t       stamp;        // Stamp from the cycle timer

    // Address of a context register pair, stride sixteen bytes
    function automatic logic [11:0] ctxAddr(input logic [2:0] n, input logic [3:0] ofs);
        ctxAddr = `ITC_CTX_BASE + {5'h00, n, 4'h0} + {8'h00, ofs}; // RQ16
    endfunction

    // Whole control word as software reads it
    function automatic logic [31:0] ctlWord(input int n);
        ctlWord = '0; // RQ8 RQ12
        ctlWord[`ITC_ARM_BIT]                    = armReg[n];
        ctlWord[`ITC_TGT_HI:`ITC_TGT_LO]          = tgtReg[n];
        ctlWord[`ITC_RUN_BIT]                    = runReg[n];
        ctlWord[`ITC_WAKE_BIT]                   = wakeReg[n];
        ctlWord[`ITC_DEAD_BIT]                   = deadReg[n];
        ctlWord[`ITC_ACT_BIT]                    = actReg[n];
        ctlWord[`ITC_CODE_HI:`ITC_CODE_LO]        = codeReg[n];
    endfunction

    // Map an engine outcome to its completion code
    function automatic itc_pkg::itc_code_t codeOf(input logic [2:0] kind);
        case (kind)
            3'(itc_pkg::ITC_DONE_COMPLETE):  codeOf = `ITC_CODE_COMPLETE;
            3'(itc_pkg::ITC_DONE_DESC_READ): codeOf = `ITC_CODE_DESC_RD;
            3'(itc_pkg::ITC_DONE_DATA_READ): codeOf = `ITC_CODE_DATA_RD;
            3'(itc_pkg::ITC_DONE_TIMEOUT):   codeOf = `ITC_CODE_TIMEOUT;
            default:                         codeOf = `ITC_CODE_UNKNOWN;
        endcase
    endfunction

    // Reset of either kind clears all context state
    assign clear   = srst | softReset;
    // Write acts only at the edge where pready is sampled high
    assign wrDone  = psel & penable & pwrite & ready_reg;
    // Read data latched at the same edge where pready rises
    assign rdStart = psel & penable & ~ready_reg;
    // Two low seconds bits with the cycle number
    assign stamp   = {timerSecondsCount[1:0], timerCycleNumber}; // RQ2

    // Address decode of the set and clear words
    always_comb begin
        for (int i = 0; i < N; i++) begin
            setSel[i] = wrDone & (paddr == ctxAddr(3'(i), `ITC_SET_OFS)); // RQ16 RQ17
            clrSel[i] = wrDone & (paddr == ctxAddr(3'(i), `ITC_CLR_OFS)); // RQ16 RQ17
        end
    end

    // One comparator per context
    for (genvar g = 0; g < N; g++) begin : gCmp
        itc_match_if mi ();
        assign mi.armed  = armReg[g] & runReg[g] & ~deadReg[g];
        assign mi.target = tgtReg[g];
        assign mi.stamp  = stamp;
        assign mi.strobe = cycleStart;
        assign hit[g]    = mi.hit;
        itc_cycle_match uCmp (
            .m (mi.cmp)
        );
    end

    // APB handshake: one wait state, so outputs stay registered
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= psel & penable & ~ready_reg;
        end
    end

    // Read data and error, captured at the edge where pready rises
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_reg <= 32'h0000_0000;
            err_reg   <= 1'b0;
        end else if (rdStart) begin
            rdata_reg <= 32'h0000_0000;
            err_reg   <= 1'b1;   // Unmapped unless a match below
            for (int i = 0; i < N; i++) begin
                // Either address of the pair returns the value
                if (paddr == ctxAddr(3'(i), `ITC_SET_OFS) ||
                    paddr == ctxAddr(3'(i), `ITC_CLR_OFS)) begin
                    rdata_reg <= pwrite ? 32'h0000_0000 : ctlWord(i); // RQ17
                    err_reg   <= 1'b0;
                end
            end
            if (paddr == `ITC_INT_STAT_ADDR) begin
                rdata_reg <= pwrite ? 32'h0000_0000 : {8'h00, intStat_reg};
                err_reg   <= 1'b0;
            end
            if (paddr == `ITC_INT_MASK_ADDR) begin
                rdata_reg <= pwrite ? 32'h0000_0000 : {8'h00, intMask_reg};
                err_reg   <= 1'b0;
            end
        end else begin
            err_reg <= 1'b0;
        end
    end

    // Run bit: only software or a reset moves it
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            runReg <= 8'h00; // RQ7
        end else begin
            runReg <= (runReg | (setSel & {N{pwdata[`ITC_RUN_BIT]}})) &
                      ~(clrSel & {N{pwdata[`ITC_RUN_BIT]}}); // RQ6
        end
    end

    // Target cycle: plain software field
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            tgtReg <= '{default: 15'h0000};
        end else begin
            for (int i = 0; i < N; i++) begin
                if (setSel[i]) begin
                    tgtReg[i] <= tgtReg[i] | pwdata[`ITC_TGT_HI:`ITC_TGT_LO]; // RQ17
                end else if (clrSel[i]) begin
                    tgtReg[i] <= tgtReg[i] & ~pwdata[`ITC_TGT_HI:`ITC_TGT_LO]; // RQ17
                end
            end
        end
    end

    // Compare arm: hardware drops it once the context is active
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            armReg <= 8'h00;
        end else begin
            armReg <= (setSel & {N{pwdata[`ITC_ARM_BIT]}}) | (armReg & ~actReg &
                      ~(clrSel & {N{pwdata[`ITC_ARM_BIT]}})); // RQ5 RQ17
        end
    end

    // Wake: software set wins over a fetch in the same cycle
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            wakeReg <= 8'h00;
        end else begin
            wakeReg <= (wakeReg & ~descFetch) | (setSel & {N{pwdata[`ITC_WAKE_BIT]}}); // RQ9
        end
    end

    // Dead: fatal error sets it, run going low clears it
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            deadReg <= 8'h00;
        end else begin
            deadReg <= runReg & (deadReg | fatalError); // RQ10
        end
    end

    // Transmit enable: immediate, or held back until the target cycle.
    // The engine may prefetch as soon as this rises: ahead of the first
    // packet's cycle on an immediate start, inside the target cycle when armed.
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            goReg <= 8'h00;
        end else begin
            goReg <= runReg & ~deadReg & ~fatalError & (goReg | ~armReg | hit); // RQ1 RQ3 RQ4
        end
    end

    // Active follows the engine while the context is enabled
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            actReg <= 8'h00;
        end else begin
            actReg <= engineBusy & goReg; // RQ11
        end
    end

    // Completion code after the last output descriptor
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            codeReg <= '{default: `ITC_CODE_RESET};
        end else if (doneValid) begin
            codeReg[doneCtx] <= codeOf(doneKind); // RQ13
        end
    end

    // Skip handling needs dead with timeout code, or rxDeadTimeout, and the fatal event
    always_comb begin
        skipOk = rxDeadTimeout;
        for (int i = 0; i < N; i++) begin
            if (deadReg[i] && codeReg[i] == `ITC_CODE_TIMEOUT) begin
                skipOk = 1'b1;
            end
        end
        skipOk = skipOk & fatalErrorEvent; // RQ15
    end

    // Skip budget: seven per running context, refilled by a packet
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            skipReg <= '{default: 3'h0};
            skipOut_reg <= 8'h00;
            ovfFail     <= 8'h00;
        end else begin
            for (int i = 0; i < N; i++) begin
                skipOut_reg[i] <= 1'b0;
                ovfFail[i]     <= 1'b0;
                if (!runReg[i] || (doneValid && doneCtx == 3'(i))) begin
                    skipReg[i] <= 3'h0;
                end else if (overflow[i] && skipOk) begin
                    if (skipReg[i] < `ITC_MAX_SKIPS) begin
                        skipReg[i]     <= skipReg[i] + 3'h1; // RQ14
                        skipOut_reg[i] <= 1'b1;
                    end else begin
                        ovfFail[i] <= 1'b1; // RQ14
                    end
                end else if (overflow[i]) begin
                    ovfFail[i] <= 1'b1; // RQ15
                end
            end
        end
    end

    // Interrupt status: events set, writing one clears, set wins
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            intStat_reg <= 24'h000000;
        end else begin
            intStat_reg <= (intStat_reg &
                            ~((wrDone && paddr == `ITC_INT_STAT_ADDR) ? pwdata[23:0] : 24'h0))
                           | {ovfFail,
                              (doneValid ? 8'(8'h01 << doneCtx) : 8'h00),
                              (fatalError & runReg)};
        end
    end

    // Interrupt mask, software owned
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            intMask_reg <= 24'h000000;
        end else if (wrDone && paddr == `ITC_INT_MASK_ADDR) begin
            intMask_reg <= pwdata[23:0];
        end
    end

    // Level interrupt while any unmasked status bit stands
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(intStat_reg & intMask_reg);
        end
    end

    // Outputs straight from flip-flops
    assign prdata      = rdata_reg;
    assign pready      = ready_reg;
    assign pslverr     = err_reg;
    assign ctxEnable   = goReg;
    assign wakePending = wakeReg;
    assign skipGrant   = skipOut_reg;
    assign irq         = irq_reg;
endmodule
`default_nettype wire

// ==== sim/itc_engine_model.sv ====
/*
 * Behavioural model of the descriptor engine beside itc_ctrl.
 * Assumes ctxEnable and wakePending come straight from the controller on ref_clk.
 */
`default_nettype none
module itc_engine_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // From the controller
    input  wire logic [7:0] ctxEnable,
    input  wire logic [7:0] wakePending,
    // Holds a context off, to model a slow engine
    input  wire logic [7:0] stall,
    // To the controller
    output logic      [7:0] engineBusy,
    output logic      [7:0] descFetch
);
    timeunit 1ns;
    timeprecision 1ps;
    // Busy follows enable one edge later unless held off
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            engineBusy <= 8'h00;
        end else begin
            engineBusy <= ctxEnable & ~stall;
        end
    end
    // One fetch per wake, never on two edges in a row; a stuck wake bit fetches every other edge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            descFetch <= 8'h00;
        end else begin
            descFetch <= engineBusy & wakePending & ~descFetch;
        end
    end
endmodule
`default_nettype wire

// ==== sim/itc_ctrl_chk.sv ====
/*
 * Concurrent checks on the ports of itc_ctrl.
 * Assumes one clock, ref_clk, and the synchronous reset srst.
 */
`default_nettype none
module itc_ctrl_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Timer and engine
    input wire logic        cycleStart,
    input wire logic [7:0]  descFetch,
    input wire logic [7:0]  fatalError,
    input wire logic [7:0]  overflow,
    input wire logic        fatalErrorEvent,
    input wire logic [7:0]  ctxEnable,
    input wire logic [7:0]  wakePending,
    input wire logic [7:0]  skipGrant,
    input wire logic        irq
);
    // Single domain
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Reset leaves the outputs quiet; not disabled by reset itself
    reset_quiet_a: assert property (disable iff (1'b0)
        srst |=> !irq && ctxEnable == 8'h00 && skipGrant == 8'h00) else $error("outputs not quiet");
    // Answer within two edges of the access phase
    apb_wait_a: assert property (psel && penable && !pready |-> ##[1:2] pready)
        else $error("apb answer late");
    // Answer only inside an access phase
    apb_frame_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    // Refused access returns zero data
    refuse_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("bad refusal");
    // Reserved and speed bits of a control word read zero
    rsvd_zero_a: assert property (pready && !pwrite && paddr[11:8] == 4'h2
        |-> prdata[14:13] == 2'h0 && prdata[9:5] == 5'h00) else $error("reserved bits set");
    // Enable rises only after a control write or a cycle start
    enable_cause_a: assert property ((ctxEnable & ~$past(ctxEnable)) != 8'h00
        |-> $past(cycleStart) || $past(pwrite && pready) || $past(pwrite && pready, 2))
        else $error("enable without cause");
    // A fatal error stops its context at the next edge
    fatal_stop_a: assert property (fatalError != 8'h00
        |=> (ctxEnable & $past(fatalError)) == 8'h00) else $error("context not stopped");
    // A fetch clears wake unless a write lands at the same edge
    wake_clear_a: assert property (descFetch != 8'h00 && !(pwrite && pready)
        |=> (wakePending & $past(descFetch)) == 8'h00) else $error("wake not cleared");
    // Grants only for an overflow while the fatal event is up
    skip_cause_a: assert property (skipGrant != 8'h00
        |-> (skipGrant & ~$past(overflow)) == 8'h00 && $past(fatalErrorEvent))
        else $error("grant without cause");
    // Grants are single pulses
    skip_pulse_a: assert property (skipGrant != 8'h00
        |=> (skipGrant & $past(skipGrant)) == 8'h00) else $error("grant too long");
endmodule
bind itc_ctrl itc_ctrl_chk chk (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .cycleStart, .descFetch, .fatalError, .overflow, .fatalErrorEvent,
    .ctxEnable, .wakePending, .skipGrant, .irq);
`default_nettype wire

// ==== sim/testbench.sv ====
/*
 * Self-checking bench for itc_ctrl: APB tasks, engine model, timer pulses.
 * Assumes the defines header is on the include path.
 */
`include "itc_defines.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Stimulus, all quiet at time zero
    logic        ref_clk = 1'b0, srst = 1'b1, softReset = 1'b0, cycleStart = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, doneValid = 1'b0;
    logic        fatalErrorEvent = 1'b0, rxDeadTimeout = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [6:0]  timerSecondsCount = 7'h00;
    logic [12:0] timerCycleNumber = 13'h0000;
    logic [2:0]  doneCtx = 3'h0, doneKind = 3'h0;
    logic [7:0]  fatalError = 8'h00, overflow = 8'h00, stall = 8'h00;
    // Design outputs
    logic [31:0] prdata, rd;
    logic        pready, pslverr, irq, rerr;
    logic [7:0]  ctxEnable, wakePending, skipGrant, engineBusy, descFetch;
    // Tallies
    int          err_count = 0, total_checks = 0, grants = 0;
    logic [4:0]  codes [5] = '{`ITC_CODE_COMPLETE, `ITC_CODE_DESC_RD, `ITC_CODE_DATA_RD,
                               `ITC_CODE_TIMEOUT, `ITC_CODE_UNKNOWN};
    itc_ctrl uut (.ref_clk, .srst, .softReset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cycleStart, .timerSecondsCount, .timerCycleNumber,
        .descFetch, .engineBusy, .fatalError, .doneValid, .doneCtx, .doneKind, .overflow,
        .ctxEnable, .wakePending, .skipGrant, .rxDeadTimeout, .fatalErrorEvent, .irq);
    itc_engine_model eng (.ref_clk, .srst, .ctxEnable, .wakePending, .stall, .engineBusy,
        .descFetch);
    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;
    // Count skip grants of context 2
    always @(posedge ref_clk) if (skipGrant[2] === 1'b1) grants++;
    // Compare and tally
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready however long it takes
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1);
        check(n, 2);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read and compare
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Cycle start with its timer stamp
    task cyc(input logic [6:0] s, input logic [12:0] c);
        @(posedge ref_clk);
        cycleStart <= 1'b1;
        timerSecondsCount <= s;
        timerCycleNumber <= c;
        @(posedge ref_clk);
        cycleStart <= 1'b0;
    endtask
    // Engine reports the end of a last descriptor
    task done(input logic [2:0] c, input logic [2:0] k);
        @(posedge ref_clk);
        doneValid <= 1'b1;
        doneCtx <= c;
        doneKind <= k;
        @(posedge ref_clk);
        doneValid <= 1'b0;
    endtask
    // One overflow pulse on context 2
    task ovf;
        @(posedge ref_clk) overflow <= 8'h04;
        @(posedge ref_clk) overflow <= 8'h00;
    endtask
    // Verdict and end of run
    task close_out;
        $display("Checks made %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        rdchk(12'h200, 32'h0000_0000);
        rdchk(12'h208, 32'h0000_0000);
        check({31'h0, rerr}, 32'h1);
        $display("Reset and refusal test done");
        // Each context: run with wake, then stop
        for (int n = 0; n < 8; n++) begin
            apb(1'b1, 12'h200 + 12'(16 * n), {1'b0, 15'(n + 1), 16'h9000});
            tick(3);
            check({31'h0, ctxEnable[n]}, 32'h1);
            rdchk(12'h204 + 12'(16 * n), {1'b0, 15'(n + 1), 16'h8400});
            apb(1'b1, 12'h204 + 12'(16 * n), 32'h0000_8000);
            tick(3);
            rdchk(12'h200 + 12'(16 * n), {1'b0, 15'(n + 1), 16'h0000});
        end
        $display("Context map test done");
        // Set and clear all ones; wake survives the clear address
        stall <= 8'h80;
        apb(1'b1, 12'h270, 32'hffff_ffff);
        rdchk(12'h274, 32'hffff_9000);
        apb(1'b1, 12'h274, 32'hffff_ffff);
        rdchk(12'h270, 32'h0000_1000);
        $display("Set and clear test done");
        // Armed start, engine held off so arm must wait for active
        stall <= 8'h04;
        apb(1'b1, 12'h224, 32'h7fff_0000);
        apb(1'b1, 12'h220, 32'ha345_8000);
        cyc(7'h05, 13'h0344);
        tick(2);
        check({24'h0, ctxEnable}, 32'h0000_0000);
        cyc(7'h7d, 13'h0345);
        tick(1);
        check({24'h0, ctxEnable}, 32'h0000_0004);
        rdchk(12'h220, 32'ha345_8000);
        stall <= 8'h00;
        tick(4);
        rdchk(12'h220, 32'h2345_8400);
        $display("Cycle compare test done");
        // Fatal error with interrupt masked, then unmasked
        @(posedge ref_clk) fatalError <= 8'h04;
        @(posedge ref_clk) fatalError <= 8'h00;
        tick(3);
        check({31'h0, irq}, 32'h0);
        rdchk(12'h220, 32'h2345_8800);
        apb(1'b1, 12'h304, 32'h0000_0004);
        tick(2);
        check({31'h0, irq}, 32'h1);
        // Timeout code, then skips: none without the event, seven with it
        done(3'h2, 3'h3);
        rdchk(12'h220, 32'h2345_880a);
        ovf;
        tick(2);
        check(grants, 0);
        fatalErrorEvent <= 1'b1;
        repeat (8) ovf;
        tick(2);
        check(grants, 7);
        rdchk(12'h300, 32'h0004_0404);
        apb(1'b1, 12'h300, 32'h0004_0404);
        tick(2);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h224, 32'h0000_8000);
        tick(2);
        rdchk(12'h220, 32'h2345_000a);
        $display("Fatal and skip test done");
        // Every completion outcome on context 3
        for (int k = 0; k < 5; k++) begin
            done(3'h3, 3'(k));
            rdchk(12'h230, {16'h0004, 11'h000, codes[k]});
        end
        $display("Completion code test done");
        // Software reset clears run
        apb(1'b1, 12'h220, 32'h0000_8000);
        @(posedge ref_clk) softReset <= 1'b1;
        @(posedge ref_clk) softReset <= 1'b0;
        tick(2);
        rdchk(12'h220, 32'h0000_0000);
        $display("Software reset test done");
        close_out;
    end
    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        #300000;
        err_count++;
        close_out;
    end
endmodule
`default_nettype wire
